// [hw/adc_trigger_and_sequencer.sv]
// trigger selection, timing and channel sequencing for a 10-bit sar converter
//
// What this block does
// R1: trigger select picks software, pulse, timer8, pin
// R2: software changes trigger select only while stopped
// R3: control bits 5,4,1,0 read one, ignore writes
// R4: clock select sets conversion time 530..68
// R5: software changes clock select only while stopped
// R6: successive approximation, ten bit result
// R7: software stops before changing mode or channel
// R8: mode change and start in one write
// R9: single mode converts selected channel once
// R10: single result stored in channel's data register
// R11: completion sets done flag, irq if enabled
// R12: start reads one, clears itself at end
// R13: scan starts at group first channel
// R14: scan results stored per channel in order
// R15: group end sets flag, irq, restarts group
// R16: scan repeats until start cleared, then waits
// R17: start delay, then sample, then approximation
// R18: start delay 18-33, 10-17, 6-9, 4-5
// R19: sampling 127, 63, 31, 15 states
// R20: later scan conversions 512, 256, 128, 64
// R21: done clears by zero write after read
// R22: pin falling edge sets start bit
// R23: pin synchronised and edge detected first
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module adc_trigger_and_sequencer
    import adc_seq_pkg::*;
#(
    parameter int NUM_CH = 10,                      // analog inputs served
    parameter int DATA_W = 16                       // register read width
) (
    input  wire logic                  i_clock,     // system clock
    input  wire logic                  i_rst_n,     // async reset, low
    input  wire logic [ADDR_W-1:0]     i_addr,      // register address
    input  wire logic [7:0]            i_wdata,     // write data
    input  wire logic                  i_wr,        // write strobe
    input  wire logic                  i_rd,        // read strobe
    output logic      [DATA_W-1:0]     o_rdata,     // read data, next cycle
    input  wire logic                  i_pulse_unit_trigger, // timer pulse
    input  wire logic                  i_timer8_trigger,     // timer pulse
    input  wire logic                  i_external_conversion_trigger_pin_n, // pin
    input  wire logic                  i_compare_above,      // comparator
    output logic                       o_sample_hold,        // sampling
    output logic      [RESULT_W-1:0]   o_trial_code,         // dac code
    output logic      [3:0]            o_channel,            // mux select
    output logic                       o_conversion_end_irq  // irq request
);

    //------------------------------------------------------------------
    // elaboration checks
    //------------------------------------------------------------------
    if (NUM_CH < 1 || NUM_CH > 12) begin : g_bad_ch
        $error("NUM_CH must lie in 1..12");
    end
    if (DATA_W < RESULT_W) begin : g_bad_w
        $error("DATA_W must hold a result");
    end

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    conv_state_e          state;
    logic                 conversion_start_bit;
    logic                 conversion_done_flag;
    logic                 conversion_irq_enable;
    logic                 scan_mode;
    logic [3:0]           chan_sel;
    logic [1:0]           trigger_select;
    logic [1:0]           conversion_clock_select;
    logic                 done_read_armed;
    logic                 scan_later;
    logic [3:0]           cur_ch;
    logic [7:0]           cnt;
    logic [3:0]           bit_idx;
    logic [RESULT_W-1:0]  sar;
    logic [3:0]           prescale;
    logic [2:0]           pin_sync;
    logic [1:0]           cmp_sync;
    logic [RESULT_W-1:0]  result_mem [NUM_CH];

    //------------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------------
    // pin passes two flops, third flop feeds the edge detector
    // the comparator answers a trial code three clocks late
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_sync <= 3'h7;
            cmp_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[1:0], i_external_conversion_trigger_pin_n}; // R23
            cmp_sync <= {cmp_sync[0], i_compare_above};
        end
    end

    // free running prescaler gives the start delay its phase spread
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prescale <= 4'h0;
        end else begin
            prescale <= prescale + 4'h1;
        end
    end

    //------------------------------------------------------------------
    // register decode
    //------------------------------------------------------------------
    wire       sel_csr   = (i_addr == CSR_OFFSET);
    wire       sel_ctrl  = (i_addr == CTRL_OFFSET);
    wire [3:0] data_idx  = i_addr - DATA_BASE;
    wire       sel_data  = (i_addr >= DATA_BASE) && (data_idx < 4'(NUM_CH));

    wire       wr_csr    = i_wr && sel_csr;
    wire       wr_ctrl   = i_wr && sel_ctrl;

    wire [7:0] csr_value  = {conversion_done_flag, conversion_irq_enable,
                             conversion_start_bit, scan_mode, chan_sel};
    wire [7:0] ctrl_value = CTRL_ONES                                  // R3
                          | {trigger_select, 2'h0, conversion_clock_select, 2'h0};

    // read mux, unmapped addresses read zero
    wire [DATA_W-1:0] read_value =
        sel_csr  ? DATA_W'(csr_value) :
        sel_ctrl ? DATA_W'(ctrl_value) :
        sel_data ? DATA_W'(result_mem[data_idx]) :
                   DATA_W'(0);

    //------------------------------------------------------------------
    // trigger selection
    //------------------------------------------------------------------
    wire pin_fall  = pin_sync[2] && !pin_sync[1];                     // R23

    wire hw_trig   = (trigger_select == TRG_PULSE_UNIT && i_pulse_unit_trigger)
                   || (trigger_select == TRG_TIMER8 && i_timer8_trigger) // R1
                   || (trigger_select == TRG_EXTERNAL && pin_fall);      // R22

    // a trigger while busy is lost
    wire sw_start  = wr_csr && i_wdata[START_BIT];
    wire sw_stop   = wr_csr && !i_wdata[START_BIT];                      // R16
    wire start_evt = !conversion_start_bit && (sw_start || hw_trig);     // R9

    //------------------------------------------------------------------
    // sequencing decode
    //------------------------------------------------------------------
    wire [1:0] ck        = conversion_clock_select;
    wire [3:0] new_chan  = wr_csr ? i_wdata[3:0] : chan_sel;         // R8
    wire       new_scan  = wr_csr ? i_wdata[SCAN_BIT] : scan_mode;
    wire [3:0] first_ch  = new_scan ? {new_chan[3:2], 2'h0} : new_chan; // R13
    wire [3:0] grp_first = {chan_sel[3:2], 2'h0};
    wire       grp_last  = (cur_ch[1:0] == chan_sel[1:0]);

    // start delay phase follows the write's timing
    wire [7:0] delay_ld  = DELAY_MIN_STATES[ck] - 8'h01              // R18
                         + ((~{4'h0, prescale}) & DELAY_SPAN_MASK[ck]);
    wire [7:0] tail_ld   = scan_later ? SCAN_TAIL[ck] : SINGLE_TAIL[ck]; // R20

    wire       cnt_zero  = (cnt == 8'h00);
    wire       finish    = (state == ST_TAIL) && cnt_zero;
    wire       group_end = finish && (!scan_mode || grp_last);

    wire [RESULT_W-1:0] sar_decided = cmp_sync[1] ? sar
                                    : (sar & ~(RESULT_W'(1) << bit_idx)); // R6

    //------------------------------------------------------------------
    // control and status bits
    //------------------------------------------------------------------
    // mode, channel, enable and control fields are plain writes
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conversion_irq_enable   <= 1'b0;
            scan_mode               <= 1'b0;
            chan_sel                <= CHAN_RESET;
            trigger_select          <= TRGSEL_RESET;
            conversion_clock_select <= CKSEL_RESET;
        end else begin
            if (wr_csr) begin
                conversion_irq_enable <= i_wdata[IEN_BIT];
                scan_mode             <= i_wdata[SCAN_BIT];
                chan_sel              <= i_wdata[3:0];
            end

            if (wr_ctrl) begin
                trigger_select          <= i_wdata[TRGSEL_LSB +: 2];
                conversion_clock_select <= i_wdata[CKSEL_LSB +: 2];
            end
        end
    end

    // done flag: set wins over clear; clear needs a prior read of one
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            conversion_done_flag <= 1'b0;
            done_read_armed      <= 1'b0;
        end else begin
            if (group_end) begin
                conversion_done_flag <= 1'b1;                         // R11 R15
            end else if (wr_csr && !i_wdata[DONE_BIT] && done_read_armed) begin
                conversion_done_flag <= 1'b0;                         // R21
            end

            if (i_rd && sel_csr && conversion_done_flag) begin
                done_read_armed <= 1'b1;
            end else if (wr_csr || !conversion_done_flag) begin
                done_read_armed <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------------
    // stop wins over start; one state per clock
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state                <= ST_IDLE;
            conversion_start_bit <= 1'b0;
            scan_later           <= 1'b0;
            cur_ch               <= 4'h0;
            cnt                  <= 8'h00;
            bit_idx              <= 4'h0;
            sar                  <= '0;
        end else if (sw_stop) begin
            state                <= ST_IDLE;                          // R16
            conversion_start_bit <= 1'b0;
        end else if (start_evt) begin
            state                <= ST_DELAY;                         // R17
            conversion_start_bit <= 1'b1;                             // R12
            scan_later           <= 1'b0;
            cur_ch               <= first_ch;                         // R13
            cnt                  <= delay_ld;                         // R18
        end else begin
            case (state)
                // wait for a start
                ST_IDLE: begin
                    cnt <= 8'h00;
                end

                // start delay
                ST_DELAY: begin
                    if (cnt_zero) begin
                        state <= ST_SAMPLE;
                        cnt   <= SAMPLE_STATES[ck] - 8'h01;           // R19
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end

                // hold the input
                ST_SAMPLE: begin
                    if (cnt_zero) begin
                        state   <= ST_CONVERT;
                        sar     <= RESULT_W'(1) << (RESULT_W - 1);
                        bit_idx <= 4'(RESULT_W - 1);
                        cnt     <= SAR_STEP_STATES[ck] - 8'h01;        // R4
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end

                // one bit per step
                ST_CONVERT: begin
                    if (cnt_zero) begin
                        if (bit_idx == 4'h0) begin
                            sar   <= sar_decided;                     // R6
                            state <= ST_TAIL;
                            cnt   <= tail_ld;
                        end else begin
                            sar     <= sar_decided
                                     | (RESULT_W'(1) << (bit_idx - 4'h1));
                            bit_idx <= bit_idx - 4'h1;
                            cnt     <= SAR_STEP_STATES[ck] - 8'h01;
                        end
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end

                // settle, then store
                ST_TAIL: begin
                    if (!cnt_zero) begin
                        cnt <= cnt - 8'h01;
                    end else if (!scan_mode) begin
                        state                <= ST_IDLE;              // R9
                        conversion_start_bit <= 1'b0;                 // R12
                    end else begin
                        state      <= ST_SAMPLE;                      // R16
                        scan_later <= 1'b1;                           // R20
                        cur_ch     <= grp_last ? grp_first            // R15
                                               : cur_ch + 4'h1;       // R14
                        cnt        <= SAMPLE_STATES[ck] - 8'h01;      // R19
                    end
                end

                // stray codes idle
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // result storage
    //------------------------------------------------------------------
    // the finished code lands in the register of the converted channel
    // a stopped conversion keeps the old result
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result_mem[i] <= '0;
            end
        end else if (finish && !sw_stop && !start_evt
                     && cur_ch < 4'(NUM_CH)) begin
            result_mem[cur_ch] <= sar;                                // R10 R14
        end
    end

    //------------------------------------------------------------------
    // registered outputs
    //------------------------------------------------------------------
    // outputs come straight from flops
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata              <= '0;
            o_sample_hold        <= 1'b0;
            o_trial_code         <= '0;
            o_channel            <= 4'h0;
            o_conversion_end_irq <= 1'b0;
        end else begin
            o_rdata              <= i_rd ? read_value : '0;
            o_sample_hold        <= (state == ST_SAMPLE);             // R17
            o_trial_code         <= sar;
            o_channel            <= cur_ch;
            o_conversion_end_irq <= conversion_done_flag
                                  && conversion_irq_enable;            // R11
        end
    end

endmodule // adc_trigger_and_sequencer

`default_nettype wire

// [hw/adc_seq_pkg.sv]
// constants and types shared by the converter trigger and sequencer
package adc_seq_pkg;

    //--------------------------------------------------------------
    // register map and field positions
    //--------------------------------------------------------------
    localparam int          ADDR_W        = 4;
    localparam int          RESULT_W      = 10;
    localparam logic [3:0]  CSR_OFFSET    = 4'h0;
    localparam logic [3:0]  CTRL_OFFSET   = 4'h1;
    localparam logic [3:0]  DATA_BASE     = 4'h2;
    localparam int          DONE_BIT      = 7;
    localparam int          IEN_BIT       = 6;
    localparam int          START_BIT     = 5;
    localparam int          SCAN_BIT      = 4;
    localparam int          TRGSEL_LSB    = 6;
    localparam int          CKSEL_LSB     = 2;
    localparam logic [7:0]  CTRL_ONES     = 8'h33;
    localparam logic [3:0]  CHAN_RESET    = 4'h0;
    localparam logic [1:0]  TRGSEL_RESET  = 2'h0;
    localparam logic [1:0]  CKSEL_RESET   = 2'h0;

    //--------------------------------------------------------------
    // trigger source encodings
    //--------------------------------------------------------------
    localparam logic [1:0]  TRG_SOFTWARE   = 2'h0;
    localparam logic [1:0]  TRG_PULSE_UNIT = 2'h1;
    localparam logic [1:0]  TRG_TIMER8     = 2'h2;
    localparam logic [1:0]  TRG_EXTERNAL   = 2'h3;

    //--------------------------------------------------------------
    // timing in states (one state is one clock), by clock select
    //--------------------------------------------------------------
    typedef logic [7:0] count_t;
    localparam count_t DELAY_MIN_STATES [4] = '{8'h12, 8'h0a, 8'h06, 8'h04};
    localparam count_t DELAY_SPAN_MASK  [4] = '{8'h0f, 8'h07, 8'h03, 8'h01};
    localparam count_t SAMPLE_STATES    [4] = '{8'h7f, 8'h3f, 8'h1f, 8'h0f};
    localparam count_t SAR_STEP_STATES  [4] = '{8'h25, 8'h12, 8'h09, 8'h04};
    localparam count_t SINGLE_TAIL      [4] = '{8'h00, 8'h06, 8'h04, 8'h08};
    localparam count_t SCAN_TAIL        [4] = '{8'h0e, 8'h0c, 8'h06, 8'h08};

    //--------------------------------------------------------------
    // sequencer states
    //--------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE    = 5'b00001,
        ST_DELAY   = 5'b00010,
        ST_SAMPLE  = 5'b00100,
        ST_CONVERT = 5'b01000,
        ST_TAIL    = 5'b10000
    } conv_state_e;

endpackage

// [sim/analog_input_model.sv]
// comparator model of the analog inputs behind the converter
`timescale 1ns/1ns
`default_nettype none
module analog_input_model (
    input  wire logic [9:0] i_trial_code,   // dac trial code
    input  wire logic [3:0] i_channel,      // selected input
    output logic            o_compare_above // input at or above trial
);
    logic [9:0] level; // held level of the selected input
    // fixed level per channel, compared with the trial code
    assign level = 10'h0a5 + {6'h00, i_channel} * 10'h05b;
    assign o_compare_above = level >= i_trial_code;
endmodule // analog_input_model
`default_nettype wire

// [sim/adc_seq_asserts.sv]
// port checker for the converter trigger and sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_seq_asserts
    import adc_seq_pkg::*;
#(
    parameter int NUM_CH = 10, // analog inputs served
    parameter int DATA_W = 16  // register read width
) (
    input wire logic                i_clock,  // clock
    input wire logic                i_rst_n,  // reset, low
    input wire logic [ADDR_W-1:0]   i_addr,   // address
    input wire logic [7:0]          i_wdata,  // write data
    input wire logic                i_wr,     // write strobe
    input wire logic                i_rd,     // read strobe
    input wire logic [DATA_W-1:0]   o_rdata,  // read data
    input wire logic                i_pulse_unit_trigger,  // trigger
    input wire logic                i_timer8_trigger,      // trigger
    input wire logic                i_external_conversion_trigger_pin_n, // pin
    input wire logic                i_compare_above,       // comparator
    input wire logic                o_sample_hold,         // sampling
    input wire logic [RESULT_W-1:0] o_trial_code,          // trial code
    input wire logic [3:0]          o_channel,             // channel
    input wire logic                o_conversion_end_irq   // irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] smp_cnt; // cycles spent sampling so far
    //----------------------------------------
    // sampling length counter
    //----------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            smp_cnt <= 8'h00;
        end else begin
            smp_cnt <= o_sample_hold ? smp_cnt + 8'h01 : 8'h00;
        end
    end
    //----------------------------------------
    // properties
    //----------------------------------------
    ctrl_ones_a: assert property (i_rd && i_addr == CTRL_OFFSET |=>
        (o_rdata & 16'h0033) == 16'h0033) else $error("control ones bits lost");
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data outside read cycle");
    sample_len_a: assert property ($fell(o_sample_hold) |->
        smp_cnt inside {8'h7f, 8'h3f, 8'h1f, 8'h0f}) else $error("sampling length wrong");
    irq_clear_a: assert property ($fell(o_conversion_end_irq) |->
        $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3)) else $error("irq fell unasked");
    chan_stable_a: assert property (o_sample_hold && $past(o_sample_hold) |->
        $stable(o_channel)) else $error("channel moved in sampling");
    chan_range_a: assert property (int'(o_channel) < NUM_CH)
        else $error("channel out of range");
    sar_first_a: assert property ($fell(o_sample_hold) |->
        ##[0:2] o_trial_code == 10'h200) else $error("first trial not midscale");
    sar_gap_a: assert property ($fell(o_sample_hold) |-> !o_sample_hold [*8])
        else $error("sampling restarted early");
    cover property ($rose(o_conversion_end_irq));
    cover property ($fell(o_sample_hold) && o_channel == 4'h6);
    cover property (!i_external_conversion_trigger_pin_n);
endmodule // adc_seq_asserts
`default_nettype wire

// [sim/adc_trigger_and_sequencer_tb.sv]
// self-checking bench for the converter trigger and sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_trigger_and_sequencer_tb;
    import adc_seq_pkg::*;
    logic        clock, rst_n, wr, rd, pu_trg, t8_trg, pin_n, cmp;
    logic        shold, irq;
    logic [3:0]  addr, chan;
    logic [7:0]  wdata;
    logic [15:0] rdata;
    logic [9:0]  trial;
    int          err_count, n_checks, cyc;
    int          dlo[4] = '{18, 10, 6, 4};
    int          dhi[4] = '{33, 17, 9, 5};
    int          tmax[4] = '{530, 266, 134, 68};

    adc_trigger_and_sequencer dut_u (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pulse_unit_trigger(pu_trg),
        .i_timer8_trigger(t8_trg), .i_external_conversion_trigger_pin_n(pin_n),
        .i_compare_above(cmp), .o_sample_hold(shold), .o_trial_code(trial),
        .o_channel(chan), .o_conversion_end_irq(irq));
    analog_input_model model_u (.i_trial_code(trial), .i_channel(chan), .o_compare_above(cmp));

    // clock and hang guard
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    function automatic logic [15:0] level(input int n);
        return 16'(10'h0a5 + 10'(n) * 10'h05b);
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // s: 0 sampling high, 1 irq high, 2 sampling low
    task automatic wait_on(input int s, output int t);
        int k;
        k = 0;
        while ((s == 0 ? shold : s == 1 ? irq : !shold) !== 1'b1 && k < 2000) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk("wait", 16'(k < 2000), 1);
        t = cyc;
    endtask
    task automatic pulse(input logic [1:0] s);
        @(posedge clock);
        pu_trg <= (s == 2'h1);
        t8_trg <= (s == 2'h2);
        pin_n <= (s != 2'h3);
        @(posedge clock);
        pu_trg <= 1'b0;
        t8_trg <= 1'b0;
        pin_n <= 1'b1;
    endtask
    task automatic reg_check;
        logic [15:0] d;
        rd_reg(CSR_OFFSET, d);
        chk("status reset", d, 16'h0000);
        rd_reg(CTRL_OFFSET, d);
        chk("control reset", d, 16'h0033);
        wr_reg(CTRL_OFFSET, 8'hcc);
        rd_reg(CTRL_OFFSET, d);
        chk("control", d, 16'h00ff);
        rd_reg(4'hf, d);
        chk("unmapped", d, 16'h0000);
    endtask
    task automatic run_single(input logic [1:0] k, input logic [3:0] ch);
        logic [15:0] d;
        int t0, t1, t2;
        wr_reg(CTRL_OFFSET, {TRG_SOFTWARE, 2'h0, k, 2'h0});
        wr_reg(CSR_OFFSET, {4'b0110, ch});
        t0 = cyc;
        rd_reg(CSR_OFFSET, d);
        chk("busy", d[5], 1);
        wait_on(0, t1);
        chk("delay", 16'(t1 - t0 >= dlo[k] && t1 - t0 <= dhi[k] + 2), 1);
        wait_on(1, t2);
        chk("total", 16'(t2 - t0 <= tmax[k] + 3), 1);
        rd_reg(CSR_OFFSET, d);
        chk("status", d, {8'h00, 4'b1100, ch});
        rd_reg(DATA_BASE + ch, d);
        chk("result", d, level(ch));
    endtask
    task automatic done_clear;
        logic [15:0] d;
        wr_reg(CSR_OFFSET, 8'hc0);
        wr_reg(CSR_OFFSET, 8'h40);
        rd_reg(CSR_OFFSET, d);
        chk("kept", d[7], 1);
        wr_reg(CSR_OFFSET, 8'h40);
        repeat (3) @(posedge clock);
        rd_reg(CSR_OFFSET, d);
        chk("cleared", d, 16'h0040);
        chk("irq low", irq, 0);
        chk("once", shold, 0);
    endtask
    task automatic trig_src(input logic [1:0] s);
        logic [15:0] d;
        int t;
        wr_reg(CTRL_OFFSET, {s, 6'h0c});
        rd_reg(CSR_OFFSET, d);
        wr_reg(CSR_OFFSET, 8'h43);
        pulse(s == 2'h1 ? 2'h2 : 2'h1);
        repeat (6) @(posedge clock);
        rd_reg(CSR_OFFSET, d);
        chk("ignored", d[5], 0);
        pulse(s);
        repeat (4) @(posedge clock);
        rd_reg(CSR_OFFSET, d);
        chk("started", d[5], 1);
        wait_on(1, t);
        rd_reg(DATA_BASE + 4'h3, d);
        chk("trig result", d, level(3));
        rd_reg(CSR_OFFSET, d);
        chk("trig status", d, 16'h00c3);
    endtask
    task automatic run_scan;
        logic [15:0] d;
        int t0, t1, n;
        wr_reg(CTRL_OFFSET, 8'h0c);
        wr_reg(CSR_OFFSET, 8'h76);
        for (n = 0; n < 4; n++) begin
            wait_on(0, t1);
            chk("scan chan", chan, 16'(4 + n % 3));
            if (n > 1) chk("period", 16'(t1 - t0), 16'd64);
            t0 = t1;
            wait_on(2, t1);
        end
        wr_reg(CSR_OFFSET, 8'h56);
        rd_reg(CSR_OFFSET, d);
        chk("group", d, 16'h00d6);
        for (n = 4; n < 7; n++) begin
            rd_reg(DATA_BASE + n[3:0], d);
            chk("scan result", d, level(n));
        end
        repeat (100) @(posedge clock);
        chk("stopped", shold, 0);
        chk("scan irq", irq, 1);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        {wr, rd, pu_trg, t8_trg} = 4'h0;
        pin_n = 1'b1;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        reg_check;
        for (int k = 0; k < 4; k++) run_single(k[1:0], 4'(3 * k));
        done_clear;
        for (int s = 1; s < 4; s++) trig_src(s[1:0]);
        run_scan;
        summarize;
    end
endmodule // adc_trigger_and_sequencer_tb

bind adc_trigger_and_sequencer adc_seq_asserts #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) chk_u (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pulse_unit_trigger(i_pulse_unit_trigger),
    .i_timer8_trigger(i_timer8_trigger),
    .i_external_conversion_trigger_pin_n(i_external_conversion_trigger_pin_n),
    .i_compare_above(i_compare_above), .o_sample_hold(o_sample_hold),
    .o_trial_code(o_trial_code), .o_channel(o_channel),
    .o_conversion_end_irq(o_conversion_end_irq));
`default_nettype wire
